/* logic/acc_clock_control.sv */
// audio receiver clock control: recovered clock divider and pin, lock-loss
// mute, reference multiplier settings and detection status registers.
// assumes the host port logic presents byte reads and writes as strobes and
// that the recovery pll clock arrives as a level sampled on clk_sys.
//
// How it works
// RL1: output enable low keeps pin undriven
// RL2: divider select passes, halves, quarters, eighths
// RL3: auto-mute zeroes audio when both unlocked
// RL4: lock loss stops clock unless free-run set
// RL5: multiplier settings give 98.304 MHz oversampling clock
// RL6: integer 1 to 63, fraction 0 to 9999
// RL7: host keeps quotient and integer in range
// RL8: pre-divider, integer, fraction split over three registers
// RL9: pre-divider any four-bit value within limits
// RL10: host uses recommended settings per reference
// RL11: status bit 0 flags compressed stream
// RL12: status bit 1 flags coded disc surround
// RL13: frame rate estimate sets maximum clock rate
// RL14: rate codes none, 128, 256, 512
// RL15: host picks divider from rate status
// RL16: reference select picks dedicated input or master
// RL17: unused status and control bits read zero
`timescale 1ns/1ns
module acc_clock_control import acc_pkg::*; #(
    parameter int AUDIO_W = 24,
    parameter int CNT_W   = 10
) (
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    input  wire logic [7:0]         reg_addr,                   // register offset
    input  wire logic [7:0]         reg_wdata,                  // write byte
    input  wire logic               reg_wr,                     // write strobe
    input  wire logic               reg_rd,                     // read strobe
    output logic [7:0]              reg_rdata,                  // read byte, next cycle
    input  wire logic               recovery_pll_clk,           // recovery pll output level
    input  wire logic               decoder_unlock,             // decoder reports lost lock
    input  wire logic               pll_unlock,                 // recovery pll lost lock
    input  wire logic               frame_sync,                 // frame start pulse
    input  wire logic               iec61937_detect,            // compressed stream seen
    input  wire logic               coded_disc_surround_detect, // coded disc stream seen
    input  wire logic [AUDIO_W-1:0] audio_in,                   // decoded audio word
    output logic [AUDIO_W-1:0]      audio_out,                  // audio after mute
    output logic                    recovered_clock,            // divided clock, internal
    output logic                    recovered_clock_output_o,   // pin drive value
    output logic                    recovered_clock_output_oe,  // pin drive enable
    output logic                    receiver_ref_clock_select,  // 1 = master clock input
    output logic [3:0]              pll_pre_divider,
    output logic [5:0]              pll_integer,
    output logic [13:0]             pll_fraction,
    output logic                    pll_settings_legal          // fields in range
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0]   rx_ctrl1;       // reference select byte
    logic [CTRL2_W-1:0] rx_ctrl2; // clock output control
    logic [7:0]   pll_high;       // pre-divider and top of integer
    logic [7:0]   pll_mid;        // low integer and top of fraction
    logic [7:0]   pll_low;        // bottom of fraction
    logic [1:0]   npcm_flags;     // compressed and coded disc flags
    acc_rate_t    rate_code;      // maximum recovered clock rate
    logic         pll_q;          // last sample of the pll clock
    logic [2:0]   div_cnt;        // divider chain
    logic         next_clk;       // divider output before its flop
    logic         lost_lock;      // both sides report unlock
    logic         halt;           // clock held this cycle
    logic         rise;           // pll clock rising edge
    logic [1:0]   div_sel;
    logic         out_en;
    logic         auto_mute;
    logic         lol_free_run;
    logic [7:0]   next_rdata;

    // ------------------------------------------------------------
    // control field decode
    // ------------------------------------------------------------
    // lost lock needs the decoder and the recovery pll to agree
    assign div_sel      = rx_ctrl2[DIV_SEL_LSB +: 2];
    assign out_en       = rx_ctrl2[OUT_EN_BIT];
    assign auto_mute    = rx_ctrl2[AUTO_MUTE_BIT];
    assign lol_free_run = rx_ctrl2[LOL_MODE_BIT];
    assign lost_lock    = decoder_unlock && pll_unlock;
    assign halt         = lost_lock && !lol_free_run;  // see RL4
    assign rise         = recovery_pll_clk && !pll_q;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // only the reference select lives in control 1; the rest of it is elsewhere
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_ctrl1 <= RST_RX_CTRL1;
        end else if (reg_wr && reg_addr == OFS_RX_CTRL1) begin
            rx_ctrl1 <= {4'h0, reg_wdata[REF_SEL_BIT], 3'h0};
        end
    end

    // clock output control keeps only its five live bits, see RL17
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_ctrl2 <= RST_RX_CTRL2[CTRL2_W-1:0];
        end else if (reg_wr && reg_addr == OFS_RX_CTRL2) begin
            rx_ctrl2 <= reg_wdata[CTRL2_W-1:0];
        end
    end

    // multiplier configuration bytes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pll_high <= RST_PLL_HIGH;
            pll_mid  <= RST_PLL_MID;
            pll_low  <= RST_PLL_LOW;
        end else if (reg_wr) begin
            if (reg_addr == OFS_PLL_HIGH) begin
                pll_high <= reg_wdata;
            end
            if (reg_addr == OFS_PLL_MID) begin
                pll_mid <= reg_wdata;
            end
            if (reg_addr == OFS_PLL_LOW) begin
                pll_low <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // reference multiplier fields
    // ------------------------------------------------------------
    assign receiver_ref_clock_select = rx_ctrl1[REF_SEL_BIT];  // see RL16
    assign pll_pre_divider = pll_high[7:4];                     // see RL8
    assign pll_integer     = {pll_high[3:0], pll_mid[7:6]};     // see RL8
    assign pll_fraction    = {pll_mid[5:0], pll_low};           // see RL8

    // the analogue loop cannot reject bad fields; flag them on pll_settings_legal so
    // the loop control can see a multiplier outside the k range;
    // limits tied to the reference frequency are not checked here,
    // because this block never sees that frequency
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pll_settings_legal <= 1'b0;
        end else begin
            pll_settings_legal <= pll_integer >= INT_MIN   // see RL6
                               && pll_integer <= INT_MAX
                               && pll_fraction <= FRAC_MAX
                               && pll_pre_divider != 4'h0; // see RL5
        end
    end

    // ------------------------------------------------------------
    // detection status
    // ------------------------------------------------------------
    // flags follow the detector live; they are status, not sticky events
    // a one-cycle detector glitch may be missed by slow polling, traded
    // for having no clear path at all
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            npcm_flags <= 2'h0;
        end else begin
            npcm_flags[0] <= iec61937_detect;             // see RL11
            npcm_flags[1] <= coded_disc_surround_detect;  // see RL12
        end
    end

    acc_rate_estimator #(
        .CNT_W      (CNT_W)
    ) u_rate (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .locked     (!lost_lock),
        .frame_sync (frame_sync),
        .rate_code  (rate_code)   // see RL13
    );

    // ------------------------------------------------------------
    // recovered clock divider
    // ------------------------------------------------------------
    // the pll clock is sampled, so it must stay below half of clk_sys;
    // a faster clock aliases and the divider miscounts
    // edge detector on the sampled pll clock
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pll_q <= 1'b0;
        end else begin
            pll_q <= recovery_pll_clk;
        end
    end

    // ripple-free binary count; each bit is the clock divided by 2, 4, 8
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 3'h0;
        end else if (rise && !halt) begin
            div_cnt <= div_cnt + 3'h1;  // see RL4
        end
    end

    // pick the tap; passthrough is forced low while the clock is stopped
    always_comb begin
        unique case (div_sel)  // see RL2
            2'b00: next_clk = recovery_pll_clk && !halt;
            2'b01: next_clk = div_cnt[0];
            2'b10: next_clk = div_cnt[1];
            2'b11: next_clk = div_cnt[2];
        endcase
    end

    // one flop feeds both the internal clock and the pin
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            recovered_clock <= 1'b0;
        end else begin
            recovered_clock <= next_clk;
        end
    end

    assign recovered_clock_output_o  = recovered_clock;
    assign recovered_clock_output_oe = out_en;  // see RL1

    // ------------------------------------------------------------
    // audio auto-mute
    // ------------------------------------------------------------
    // one register stage for both paths, so a muted word sits in the
    // same slot as the word it replaces
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            audio_out <= '0;
        end else if (auto_mute && lost_lock) begin
            audio_out <= '0;  // see RL3
        end else begin
            audio_out <= audio_in;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    // unmapped offsets read zero so the host port never sees stale data
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            OFS_RX_CTRL1: next_rdata = rx_ctrl1;
            OFS_RX_CTRL2: next_rdata = {3'h0, rx_ctrl2};     // see RL17
            OFS_PLL_HIGH: next_rdata = pll_high;
            OFS_PLL_MID:  next_rdata = pll_mid;
            OFS_PLL_LOW:  next_rdata = pll_low;
            OFS_NPCM:     next_rdata = {6'h00, npcm_flags};  // see RL17
            OFS_RATE:     next_rdata = {6'h00, rate_code};   // see RL14
            default:      next_rdata = 8'h00;
        endcase
    end

    // read data moves only on a read strobe, so the host sees a stable byte
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pin_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL1
        (reg_wr && reg_addr == OFS_RX_CTRL2)
        |=> recovered_clock_output_oe == $past(reg_wdata[OUT_EN_BIT]))
        else $error("pin enable does not follow written bit");
    a_mute_forces_low: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL3
        (auto_mute && decoder_unlock && pll_unlock) |=> audio_out == '0)
        else $error("audio not muted on lost lock");
    a_audio_passes: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL3
        (!auto_mute || !decoder_unlock || !pll_unlock) |=> audio_out == $past(audio_in))
        else $error("audio muted without cause");
    a_clock_halts: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL4
        (halt && !reg_wr) [*2] |=> $stable(recovered_clock))
        else $error("recovered clock moves while stopped");
    a_div_two_toggle: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL2
        (div_sel == 2'b01 && rise && !halt && !reg_wr) ##1 (!reg_wr)
        |=> recovered_clock != $past(recovered_clock))
        else $error("divide by two missed an edge");
    a_npcm_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL11
        (iec61937_detect ##1 reg_rd && reg_addr == OFS_NPCM) |=> reg_rdata[0])
        else $error("compressed stream flag not reported");
    a_rate_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL17
        (reg_rd && (reg_addr == OFS_RATE || reg_addr == OFS_NPCM)) |=> reg_rdata[7:2] == 6'h00)
        else $error("unused status bits not zero");
    a_integer_split: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL8
        (reg_wr && reg_addr == OFS_PLL_MID) |=> pll_integer[1:0] == $past(reg_wdata[7:6]))
        else $error("integer low bits not taken from mid byte");
    a_zero_integer_bad: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL6
        (pll_integer == 6'h00) |=> !pll_settings_legal)
        else $error("zero integer accepted as legal");
    a_ref_select_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL16
        (reg_wr && reg_addr == OFS_RX_CTRL1)
        |=> receiver_ref_clock_select == $past(reg_wdata[REF_SEL_BIT]))
        else $error("reference select does not follow written bit");
    a_passthrough_follow: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL2
        (div_sel == 2'b00 && !halt) |=> recovered_clock == $past(recovery_pll_clk))
        else $error("passthrough clock does not follow pll clock");
    a_ctrl_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL17
        (reg_rd && reg_addr == OFS_RX_CTRL2) |=> reg_rdata[7:5] == 3'h0)
        else $error("unused control bits not zero");

endmodule

/* logic/acc_pkg.sv */
// constants shared by the audio receiver clock control block and its rate estimator.
// assumes one 10 MHz system clock and a byte-wide register port supplied by the host port logic.
package acc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_RX_CTRL1  = 8'h0D;  // holds the reference clock select
    localparam logic [7:0] OFS_RX_CTRL2  = 8'h0E;  // receiver_clock_output_control
    localparam logic [7:0] OFS_PLL_HIGH  = 8'h0F;  // ref_pll_config_high
    localparam logic [7:0] OFS_PLL_MID   = 8'h10;  // ref_pll_config_mid
    localparam logic [7:0] OFS_PLL_LOW   = 8'h11;  // ref_pll_config_low
    localparam logic [7:0] OFS_NPCM      = 8'h12;  // compressed_stream_detect_status
    localparam logic [7:0] OFS_RATE      = 8'h13;  // recovered_rate_status

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int REF_SEL_BIT   = 3;  // receiver_ref_clock_select in control 1
    localparam int OUT_EN_BIT    = 0;  // recovered_clock_out_enable
    localparam int DIV_SEL_LSB   = 1;  // recovered_clock_divider_select, two bits
    localparam int AUTO_MUTE_BIT = 3;  // lock_loss_auto_mute
    localparam int LOL_MODE_BIT  = 4;  // lock_loss_clock_mode
    localparam int CTRL2_W       = 5;  // bits 7:5 read zero

    // ------------------------------------------------------------
    // values after reset (multiplier set for a 12.288 MHz reference)
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RX_CTRL1 = 8'h00;
    localparam logic [7:0] RST_RX_CTRL2 = 8'h00;
    localparam logic [7:0] RST_PLL_HIGH = 8'h12;  // pre-divider 1, integer 8
    localparam logic [7:0] RST_PLL_MID  = 8'h00;
    localparam logic [7:0] RST_PLL_LOW  = 8'h00;

    // ------------------------------------------------------------
    // multiplier limits
    // ------------------------------------------------------------
    localparam logic [5:0]  INT_MIN  = 6'h01;
    localparam logic [5:0]  INT_MAX  = 6'h3F;
    localparam logic [13:0] FRAC_MAX = 14'h270F;  // 9999

    // ------------------------------------------------------------
    // recovered clock rate codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_RATE_NONE = 2'b00,
        ACC_RATE_128  = 2'b01,
        ACC_RATE_256  = 2'b10,
        ACC_RATE_512  = 2'b11
    } acc_rate_t;

    // ------------------------------------------------------------
    // frame period thresholds, times in ns and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int FRAME_MAX_NS    = 50000;  // slower than 20 kHz is no stream
    localparam int FRAME_128_NS    = 9259;   // faster than 108 kHz
    localparam int FRAME_256_NS    = 18518;  // faster than 54 kHz
    localparam int FRAME_MAX_CYC   = FRAME_MAX_NS / CLK_PERIOD_NS;
    localparam int FRAME_128_CYC   = FRAME_128_NS / CLK_PERIOD_NS;
    localparam int FRAME_256_CYC   = FRAME_256_NS / CLK_PERIOD_NS;

endpackage

/* logic/acc_rate_estimator.sv */
// frame rate estimator: times the gap between frame marks and grades the
// highest recovered clock rate that the recovery pll can deliver.
// assumes frame_sync is a one-cycle pulse synchronous to clk_sys.
`timescale 1ns/1ns
module acc_rate_estimator import acc_pkg::*; #(
    parameter int CNT_W = 10
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             locked,      // decoder or pll in lock
    input  wire logic             frame_sync,  // one pulse per frame
    output acc_rate_t             rate_code
);

    logic [CNT_W-1:0] gap;  // cycles since the last frame mark

    // ------------------------------------------------------------
    // gap counter, saturates just past the slowest legal frame
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gap <= '0;
        end else if (!locked || frame_sync) begin
            gap <= CNT_W'(1);
        end else if (gap <= CNT_W'(FRAME_MAX_CYC)) begin
            gap <= gap + CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // grade the period; lost lock or a stalled stream clears it
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rate_code <= ACC_RATE_NONE;
        end else if (!locked || gap > CNT_W'(FRAME_MAX_CYC)) begin
            rate_code <= ACC_RATE_NONE;  // see RL14
        end else if (frame_sync) begin
            // fast streams leave less headroom above the frame rate, see RL13
            if (gap < CNT_W'(FRAME_128_CYC)) begin
                rate_code <= ACC_RATE_128;
            end else if (gap < CNT_W'(FRAME_256_CYC)) begin
                rate_code <= ACC_RATE_256;
            end else begin
                rate_code <= ACC_RATE_512;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_rate_lock_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL14
        !locked |=> rate_code == ACC_RATE_NONE)
        else $error("rate status not cleared on lost lock");
    a_rate_fast_grade: assert property (@(posedge clk_sys) disable iff (!rst_b) // see RL13
        (locked && frame_sync && gap < CNT_W'(FRAME_128_CYC)) |=> rate_code == ACC_RATE_128)
        else $error("fast stream not graded as 128");

endmodule

/* testbench/acc_aes3_source.sv */
// stand-in for the aes3 stream source: recovery pll clock and frame marks.
// assumes clk_sys at 10 MHz; a frame gap of zero means no stream.
`timescale 1ns/1ns
module acc_aes3_source (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [9:0] frame_gap,        // cycles between frame marks
    output logic            recovery_pll_clk, // period of four system clocks
    output logic            frame_sync        // one-cycle frame mark
);
    logic [1:0] ph;    // pll phase; slower than clk_sys/2 on purpose
    logic [9:0] fcnt;  // frame gap counter
    // ------------------------------------------------------------
    // recovered clock keeps running, the device decides whether it stops
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) ph <= 2'h0;
        else ph <= ph + 2'h1;
    end
    assign recovery_pll_clk = ph[1];
    // frame marks spaced exactly frame_gap cycles apart
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fcnt <= 10'h0;
            frame_sync <= 1'b0;
        end else if (frame_gap == 10'h0) begin
            fcnt <= 10'h0;
            frame_sync <= 1'b0;
        end else begin
            frame_sync <= (fcnt >= frame_gap - 10'h1);
            fcnt <= (fcnt >= frame_gap - 10'h1) ? 10'h0 : fcnt + 10'h1;
        end
    end
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the receiver clock control block.
// assumes the stream source model drives pll clock and frame marks.
`timescale 1ns/1ns
module tb_top;
    import acc_pkg::*;
    logic clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rclk, fs, rck;
    logic [7:0] reg_addr = 0, reg_wdata = 0, rdata;
    logic du = 0, pu = 0, iec = 0, cds = 0, oe, po, rsel, legal;
    logic [23:0] audio_in = 0, audio_out, a;
    logic [3:0] pdiv;
    logic [5:0] pint;
    logic [13:0] pfrac;
    logic [9:0] frame_gap = 0;
    logic [1:0] u;
    int num_errors = 0, checks = 0, cyc = 0, n;
    logic [23:0] tbl [4] = '{{4'h1, 6'h08, 14'h0000}, {4'h1, 6'h08, 14'h1BA3},
                             {4'h1, 6'h0C, 14'h0000}, {4'h2, 6'h08, 14'h0000}};
    int gaps [3] = '{50, 120, 300};
    always #50 clk_sys = ~clk_sys;
    acc_aes3_source src (.clk_sys(clk_sys), .rst_b(rst_b), .frame_gap(frame_gap),
                         .recovery_pll_clk(rclk), .frame_sync(fs));
    acc_clock_control dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .recovery_pll_clk(rclk), .decoder_unlock(du), .pll_unlock(pu), .frame_sync(fs),
        .iec61937_detect(iec), .coded_disc_surround_detect(cds), .audio_in(audio_in),
        .audio_out(audio_out), .recovered_clock(rck), .recovered_clock_output_o(po),
        .recovered_clock_output_oe(oe), .receiver_ref_clock_select(rsel),
        .pll_pre_divider(pdiv), .pll_integer(pint), .pll_fraction(pfrac),
        .pll_settings_legal(legal));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // rdata holds until the next read, so one extra edge is safe
    task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1; reg_addr <= ad;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys); #1;
        check(rdata, exp);
    endtask
    // counts rising edges of the divided clock over 256 system cycles
    task automatic rises(output int c);
        logic p;
        c = 0;
        p = rck;
        repeat (256) begin
            @(posedge clk_sys); #1;
            if (rck && !p) c++;
            p = rck;
        end
    endtask
    function automatic logic [1:0] exp_rate(input int g);
        if (g < FRAME_128_CYC) return ACC_RATE_128;
        if (g < FRAME_256_CYC) return ACC_RATE_256;
        return ACC_RATE_512;
    endfunction
    task automatic give_verdict;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // cuts a hang short; the tests need under 20000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            give_verdict;
        end
    end
    initial begin
        void'($urandom(32'hC8D0));
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1 check(oe, 0);
        rdchk(OFS_RX_CTRL2, 8'h00);
        rdchk(OFS_PLL_HIGH, RST_PLL_HIGH);
        rdchk(8'h40, 8'h00);
        wr(OFS_RX_CTRL2, 8'hE1); rdchk(OFS_RX_CTRL2, 8'h01);
        check(oe, 1);
        wr(OFS_RX_CTRL1, 8'h08); #1 check(rsel, 1);
        wr(OFS_RX_CTRL1, 8'h00); #1 check(rsel, 0);
        $display("test registers done");
        // host keeps to the recommended table plus one random legal set
        for (int k = 0; k < 5; k++) begin
            if (k == 4) tbl[0] = {4'($urandom_range(15, 1)), 6'($urandom_range(55, 4)), 14'h0};
            wr(OFS_PLL_HIGH, tbl[k % 4][23:16]);
            wr(OFS_PLL_MID, tbl[k % 4][15:8]);
            wr(OFS_PLL_LOW, tbl[k % 4][7:0]);
            @(posedge clk_sys); #1;
            check({pdiv, pint, pfrac}, tbl[k % 4]);
            check(legal, 1);
            rdchk(OFS_PLL_MID, tbl[k % 4][15:8]);
        end
        // an integer part of zero is outside the multiplier range
        wr(OFS_PLL_HIGH, 8'h10);
        wr(OFS_PLL_MID, 8'h00);
        @(posedge clk_sys); #1;
        check(legal, 0);
        $display("test multiplier done");
        for (int k = 0; k < 8; k++) begin
            u = 2'($urandom);
            @(posedge clk_sys); iec <= u[0]; cds <= u[1];
            wr(OFS_NPCM, 8'hFF);
            rdchk(OFS_NPCM, {6'h0, u});
        end
        $display("test detect done");
        for (int m = 0; m < 2; m++) begin
            wr(OFS_RX_CTRL2, m ? 8'h08 : 8'h00);
            for (int k = 0; k < 16; k++) begin
                a = 24'($urandom); u = 2'($urandom);
                @(posedge clk_sys);
                audio_in <= a; du <= u[0]; pu <= u[1];
                @(posedge clk_sys); #1;
                check(audio_out, (m && u == 2'b11) ? 24'h0 : a);
            end
        end
        $display("test mute done");
        @(posedge clk_sys); du <= 1'b0; pu <= 1'b0;
        for (int d = 0; d < 4; d++) begin
            wr(OFS_RX_CTRL2, 8'(d * 2 + 1));
            rises(n);
            check(n >= (64 >> d) - 1 && n <= (64 >> d) + 1, 1);
            check(po, rck);
        end
        @(posedge clk_sys); du <= 1'b1; pu <= 1'b1;
        wr(OFS_RX_CTRL2, 8'h01); rises(n); check(n, 0);
        wr(OFS_RX_CTRL2, 8'h11); rises(n);
        check(n >= 63 && n <= 65, 1);
        rdchk(OFS_RATE, 8'h00);
        $display("test clock done");
        @(posedge clk_sys); du <= 1'b0; pu <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys); frame_gap <= 10'(gaps[k]);
            repeat (3 * gaps[k] + 5) @(posedge clk_sys);
            rdchk(OFS_RATE, {6'h0, exp_rate(gaps[k])});
        end
        @(posedge clk_sys); frame_gap <= 10'h0;
        repeat (FRAME_MAX_CYC + 20) @(posedge clk_sys);
        rdchk(OFS_RATE, 8'h00);
        $display("test rate done");
        give_verdict;
    end
endmodule
